// ---- verilog/scc_defs.svh ----
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH
`define SCC_A_CMD 8'h00
`define SCC_A_HIGH_SPEED_SETTING 8'h04
`define SCC_A_MIDDLE_SPEED_SETTING 8'h08
`define SCC_A_LOW_SPEED_SETTING 8'h0C
`define SCC_A_JOG 8'h10
`define SCC_A_ACC 8'h14
`define SCC_A_CFG 8'h18
`define SCC_A_DLY 8'h1C
`define SCC_A_STAT 8'h20
`define SCC_A_ACCT 8'h24
`define SCC_A_PAGE 8'h28
`define SCC_SPD_MIN 24'h000005
`define SCC_SPD_MAX 24'h98967F
`define SCC_SPD_STEP 24'h000005
`define SCC_HIGH_SPEED_SETTING_RST 24'h000E74
`define SCC_MIDDLE_SPEED_SETTING_RST 24'h00028A
`define SCC_LOW_SPEED_SETTING_RST 24'h00000A
`define SCC_JOG_MAX 17'h1869F
`define SCC_JOG_RST 17'h00001
`define SCC_ACC_MAX 7'h73
`define SCC_ACC_RST 7'h0D
`define SCC_ACCT_PPS 32'h000003E8
`define SCC_CFG_RST 13'h0189
`define SCC_DLY_MIN 12'h032
`define SCC_DLY_MAX 12'hBB8
`define SCC_DLY_STEP 12'h00A
`define SCC_ON_RST 12'h050
`define SCC_OFF_RST 12'h1F4
`define SCC_PAGES 4'hB
`define SCC_CLK_HZ 25'h0989680
`define SCC_CLK_NS 100
`define SCC_MS_NS 1000000
`define SCC_MS_CYC (`SCC_MS_NS / `SCC_CLK_NS)
`endif

// ---- verilog/scc_pkg.sv ----
package scc_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ONDLY = 5'b00010,
    ST_RUN = 5'b00100,
    ST_DECEL = 5'b01000,
    ST_OFFDLY = 5'b10000
  } scc_state_t;
  typedef struct packed {
    logic pb_fast;
    logic ls_fast;
    logic ccw_nc;
    logic cw_nc;
    logic ccw_en;
    logic cw_en;
    logic hold_inv;
    logic hold_en;
    logic [1:0] profile;
    logic [1:0] fmt;
    logic motor_en;
  } scc_cfg_t;
  typedef struct packed {
    logic pulse_a;
    logic pulse_b;
    logic dir;
    logic hold;
    logic lim_cw;
    logic lim_ccw;
  } scc_pins_t;
endpackage : scc_pkg

// ---- verilog/scc_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scc_defs.svh"
module scc_channel #(
  parameter int MS_CYCLES = `SCC_MS_CYC
) (
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [7:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_LIMIT_CW,
  input wire logic I_LIMIT_CCW,
  output logic O_PULSE_A,
  output logic O_PULSE_B,
  output logic O_DIR,
  output logic O_HOLD_OFF,
  output logic O_LIM_CW,
  output logic O_LIM_CCW
);
  import scc_pkg::*;
  scc_cfg_t cfg_q;
  scc_state_t st_q;
  scc_pins_t pins_q;
  logic [23:0] high_speed_setting_q, middle_speed_setting_q, low_speed_setting_q, cur_q, tgt_q, slope_q, acc_q;
  logic [16:0] jog_q, rem_q;
  logic [6:0] acc_code_q;
  logic [11:0] on_q, off_q, dly_q;
  logic [3:0] page_q;
  logic [31:0] acct_q;
  logic [15:0] ms_q;
  logic tick, wr_go, rd_go, wr_ok, rd_ok, dir_q, jog_mode_q, step;
  logic [1:0] sync_cw_q, sync_ccw_q;
  logic lim_cw, lim_ccw, stop_lim, start_cw, start_ccw, stop_req;
  logic [31:0] wmask, wval, rval;
  logic [24:0] acc_sum;
  logic [23:0] rate;

  function automatic logic [23:0] round5(input logic [31:0] v);
    logic [31:0] r;
    r = v + ((32'h5 - (v % 32'h5)) % 32'h5);
    if (r < 32'(`SCC_SPD_MIN)) r = 32'(`SCC_SPD_MIN);
    if (r > 32'(`SCC_SPD_MAX)) r = 32'(`SCC_SPD_MAX - `SCC_SPD_MAX % 24'h5);
    return r[23:0];
  endfunction : round5

  function automatic logic [11:0] round10(input logic [15:0] v);
    logic [15:0] r;
    r = v + ((16'hA - (v % 16'hA)) % 16'hA);
    if (r < 16'(`SCC_DLY_MIN)) r = 16'(`SCC_DLY_MIN);
    if (r > 16'(`SCC_DLY_MAX)) r = 16'(`SCC_DLY_MAX);
    return r[11:0];
  endfunction : round10

  function automatic logic [31:0] regval(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a == `SCC_A_HIGH_SPEED_SETTING) v = {8'h0, high_speed_setting_q};
    else if (a == `SCC_A_MIDDLE_SPEED_SETTING) v = {8'h0, middle_speed_setting_q};
    else if (a == `SCC_A_LOW_SPEED_SETTING) v = {8'h0, low_speed_setting_q};
    else if (a == `SCC_A_JOG) v = {15'h0, jog_q};
    else if (a == `SCC_A_ACC) v = {25'h0, acc_code_q};
    else if (a == `SCC_A_CFG) v = {19'h0, cfg_q};
    else if (a == `SCC_A_DLY) v = {4'h0, off_q, 4'h0, on_q};
    else if (a == `SCC_A_STAT) v = {23'h0, st_q, dir_q, O_LIM_CCW,
                                    O_LIM_CW, O_HOLD_OFF};
    else if (a == `SCC_A_ACCT) v = acct_q;
    else if (a == `SCC_A_PAGE) v = {28'h0, page_q};
    return v;
  endfunction : regval

  function automatic logic known(input logic [7:0] a);
    return a <= `SCC_A_PAGE && a[1:0] == 2'b00;
  endfunction : known

  // Bus slave: address and data taken together, one answer each
  assign wr_go = I_AWVALID && I_WVALID && !O_AWREADY && !O_BVALID;
  assign rd_go = I_ARVALID && !O_ARREADY && !O_RVALID;
  assign wr_ok = O_AWREADY && known(I_AWADDR);
  assign rd_ok = known(I_ARADDR);
  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign wmask[8*b +: 8] = {8{I_WSTRB[b]}};
  end
  always_comb wval = (regval(I_AWADDR) & ~wmask) | (I_WDATA & wmask);
  always_comb rval = regval(I_ARADDR);

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= 2'h0;
    end else begin
      O_AWREADY <= wr_go;
      O_WREADY <= wr_go;
      if (O_AWREADY) begin
        O_BVALID <= 1'b1;
        O_BRESP <= known(I_AWADDR) ? 2'h0 : 2'h2;
      end else if (I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0;
      O_RRESP <= 2'h0;
    end else begin
      O_ARREADY <= rd_go;
      if (O_ARREADY) begin
        O_RVALID <= 1'b1;
        O_RDATA <= rval;
        O_RRESP <= rd_ok ? 2'h0 : 2'h2;
      end else if (I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  // Settings written by software
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      high_speed_setting_q <= `SCC_HIGH_SPEED_SETTING_RST;
      middle_speed_setting_q <= `SCC_MIDDLE_SPEED_SETTING_RST;
      low_speed_setting_q <= `SCC_LOW_SPEED_SETTING_RST;
      jog_q <= `SCC_JOG_RST;
      acc_code_q <= `SCC_ACC_RST;
      cfg_q <= `SCC_CFG_RST;
      on_q <= `SCC_ON_RST;
      off_q <= `SCC_OFF_RST;
    end else if (wr_ok) begin
      if (I_AWADDR == `SCC_A_HIGH_SPEED_SETTING) high_speed_setting_q <= round5(wval);
      else if (I_AWADDR == `SCC_A_MIDDLE_SPEED_SETTING) middle_speed_setting_q <= round5(wval);
      else if (I_AWADDR == `SCC_A_LOW_SPEED_SETTING) low_speed_setting_q <= round5(wval);
      else if (I_AWADDR == `SCC_A_JOG)
        jog_q <= (wval == 32'h0) ? 17'h1 :
                 (wval > 32'(`SCC_JOG_MAX)) ? `SCC_JOG_MAX : wval[16:0];
      else if (I_AWADDR == `SCC_A_ACC)
        acc_code_q <= (wval > 32'(`SCC_ACC_MAX)) ? `SCC_ACC_MAX :
                      wval[6:0];
      else if (I_AWADDR == `SCC_A_CFG) cfg_q <= wval[12:0];
      else if (I_AWADDR == `SCC_A_DLY) begin
        on_q <= round10(wval[15:0]);
        off_q <= round10(wval[31:16]);
      end
    end
  end

  // Page index, jog clicks wrap around the eleven pages
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      page_q <= 4'h0;
    end else if (wr_ok && I_AWADDR == `SCC_A_CMD) begin
      if (wval[5]) page_q <= (page_q == `SCC_PAGES - 4'h1) ? 4'h0 :
                             page_q + 4'h1;
      else if (wval[6]) page_q <= (page_q == 4'h0) ?
                                  `SCC_PAGES - 4'h1 : page_q - 4'h1;
    end
  end

  // Time to change speed by 1000 pps, in ms
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) acct_q <= 32'h0;
    else acct_q <= `SCC_ACCT_PPS / {25'h0, acc_code_q + 7'h1};
  end

  // Limit inputs synchronised, then contact polarity applied
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      sync_cw_q <= 2'b00;
      sync_ccw_q <= 2'b00;
    end else begin
      sync_cw_q <= {sync_cw_q[0], I_LIMIT_CW};
      sync_ccw_q <= {sync_ccw_q[0], I_LIMIT_CCW};
    end
  end
  assign lim_cw = sync_cw_q[1] ^ cfg_q.cw_nc;
  assign lim_ccw = sync_ccw_q[1] ^ cfg_q.ccw_nc;
  assign stop_lim = dir_q ? (cfg_q.cw_en && lim_cw) :
                    (cfg_q.ccw_en && lim_ccw);

  // Commands: bit0 jog cw, bit1 jog ccw, bit2 run cw, bit3 run ccw
  assign start_cw = wr_ok && I_AWADDR == `SCC_A_CMD &&
                    (wval[0] || wval[2]) && cfg_q.motor_en &&
                    !(cfg_q.cw_en && lim_cw);
  assign start_ccw = wr_ok && I_AWADDR == `SCC_A_CMD &&
                     (wval[1] || wval[3]) && cfg_q.motor_en &&
                     !(cfg_q.ccw_en && lim_ccw);
  assign stop_req = wr_ok && I_AWADDR == `SCC_A_CMD && wval[4];

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) ms_q <= 16'h0;
    else if (tick) ms_q <= 16'h0;
    else ms_q <= ms_q + 16'h1;
  end
  assign tick = ms_q == 16'(MS_CYCLES - 1);

  assign rate = {17'h0, acc_code_q} + 24'h1;
  assign acc_sum = {1'b0, acc_q} + {1'b0, cur_q};
  assign step = (st_q == ST_RUN || st_q == ST_DECEL) &&
                acc_sum >= `SCC_CLK_HZ;

  // Motion sequencer
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      st_q <= ST_IDLE;
      dir_q <= 1'b1;
      jog_mode_q <= 1'b0;
      rem_q <= 17'h0;
      dly_q <= 12'h0;
      cur_q <= 24'h0;
      tgt_q <= 24'h0;
      slope_q <= 24'h1;
      acc_q <= 24'h0;
    end else begin
      acc_q <= step ? 24'(acc_sum - `SCC_CLK_HZ) :
               (st_q == ST_RUN || st_q == ST_DECEL) ? acc_sum[23:0] :
               24'h0;
      case (st_q)
        ST_IDLE, ST_OFFDLY: begin
          if (start_cw || start_ccw) begin
            dir_q <= start_cw;
            jog_mode_q <= wval[0] || wval[1];
            rem_q <= jog_q;
            cur_q <= low_speed_setting_q;
            tgt_q <= (wval[0] || wval[1]) ? low_speed_setting_q : high_speed_setting_q;
            slope_q <= 24'h1;
            dly_q <= on_q;
            st_q <= (cfg_q.hold_en && st_q == ST_IDLE) ?
                    ST_ONDLY : ST_RUN;
          end else if (st_q == ST_OFFDLY && tick) begin
            dly_q <= dly_q - 12'h1;
            if (dly_q <= 12'h1) st_q <= ST_IDLE;
          end
        end
        ST_ONDLY: begin
          if (stop_req || !cfg_q.motor_en) st_q <= ST_IDLE;
          else if (tick) begin
            dly_q <= dly_q - 12'h1;
            if (dly_q <= 12'h1) st_q <= ST_RUN;
          end
        end
        ST_RUN, ST_DECEL: begin
          if (step && jog_mode_q) rem_q <= rem_q - 17'h1;
          if (cfg_q.profile == 2'd0) begin
            cur_q <= (st_q == ST_DECEL) ? low_speed_setting_q : tgt_q;
          end else if (tick) begin
            slope_q <= (cfg_q.profile == 2'd2 && slope_q < rate) ?
                       slope_q + 24'h1 : rate;
            if (st_q == ST_DECEL)
              cur_q <= (cur_q > low_speed_setting_q + slope_q) ? cur_q - slope_q :
                       low_speed_setting_q;
            else if (cur_q < tgt_q)
              cur_q <= (tgt_q - cur_q > slope_q) ? cur_q + slope_q :
                       tgt_q;
          end
          if (!cfg_q.motor_en || (jog_mode_q && step && rem_q == 17'h1)
              || (stop_lim && cfg_q.ls_fast)
              || (stop_req && cfg_q.pb_fast)
              || (st_q == ST_DECEL && cur_q <= low_speed_setting_q)) begin
            dly_q <= off_q;
            st_q <= cfg_q.hold_en ? ST_OFFDLY : ST_IDLE;
          end else if (stop_lim || stop_req) begin
            slope_q <= rate;
            st_q <= ST_DECEL;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Output pins
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      pins_q <= '0;
    end else begin
      pins_q.pulse_a <= step && (cfg_q.fmt != 2'd0 || dir_q);
      pins_q.pulse_b <= step && cfg_q.fmt == 2'd0 && !dir_q;
      pins_q.dir <= (cfg_q.fmt == 2'd2) ? !dir_q : dir_q;
      pins_q.hold <= (cfg_q.hold_en && st_q == ST_IDLE)
                     ^ cfg_q.hold_inv;
      pins_q.lim_cw <= lim_cw || !cfg_q.motor_en;
      pins_q.lim_ccw <= lim_ccw || !cfg_q.motor_en;
    end
  end
  assign O_PULSE_A = pins_q.pulse_a;
  assign O_PULSE_B = pins_q.pulse_b;
  assign O_DIR = pins_q.dir;
  assign O_HOLD_OFF = pins_q.hold;
  assign O_LIM_CW = pins_q.lim_cw;
  assign O_LIM_CCW = pins_q.lim_ccw;

  chk_page_range: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    page_q < `SCC_PAGES) else $error("page index out of range");
  chk_speed_mult: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    high_speed_setting_q % 24'h5 == 24'h0 && high_speed_setting_q >= `SCC_SPD_MIN)
    else $error("high speed not a multiple of five");
  chk_disable_lim: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    !cfg_q.motor_en |=> O_LIM_CW && O_LIM_CCW)
    else $error("limits not shown while disabled");
  chk_two_pulse: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    step && cfg_q.fmt == 2'd0 && !dir_q |=> O_PULSE_B && !O_PULSE_A)
    else $error("ccw step not on second line");
  chk_dir_level: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    cfg_q.fmt == 2'd2 |=> O_DIR == !$past(dir_q))
    else $error("reversed direction level wrong");
  chk_hold_idle: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    st_q == ST_IDLE && cfg_q.hold_en && !cfg_q.hold_inv |=> O_HOLD_OFF)
    else $error("hold-off missing while stopped");
  chk_no_step_dly: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    st_q == ST_ONDLY |=> !O_PULSE_A && !O_PULSE_B)
    else $error("step during on-delay");
  chk_dly_range: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    on_q >= `SCC_DLY_MIN && off_q <= `SCC_DLY_MAX && on_q % 12'hA == 12'h0)
    else $error("delay setting out of range");
  chk_fast_stop: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    st_q == ST_RUN && stop_lim && cfg_q.ls_fast |=> st_q != ST_RUN)
    else $error("fast limit stop did not stop");
  cov_jog: cover property (@(posedge I_CLOCK) disable iff (I_RESET)
    st_q == ST_RUN && jog_mode_q ##1 st_q == ST_IDLE);
  cov_decel: cover property (@(posedge I_CLOCK) disable iff (I_RESET)
    st_q == ST_DECEL);
  cov_offdly: cover property (@(posedge I_CLOCK) disable iff (I_RESET)
    st_q == ST_OFFDLY ##1 st_q == ST_IDLE);
endmodule : scc_channel
`default_nettype wire

// ---- test/scc_motor_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module scc_motor_model (
  input wire logic i_clock,
  input wire logic i_pulse_a,
  input wire logic i_pulse_b,
  input wire logic i_dir,
  input wire logic i_cw_hit,
  input wire logic i_ccw_hit,
  input wire logic i_cw_nc,
  input wire logic i_ccw_nc,
  output logic o_cw_contact,
  output logic o_ccw_contact,
  output int o_cnt_a,
  output int o_cnt_b,
  output logic o_dir_seen
);
  // Switch closes when hit if normally open, opens if normally closed
  assign o_cw_contact = i_cw_hit ^ i_cw_nc;
  assign o_ccw_contact = i_ccw_hit ^ i_ccw_nc;
  int cnt_a = 0;
  int cnt_b = 0;
  logic dir_seen = 1'b0;
  assign o_cnt_a = cnt_a;
  assign o_cnt_b = cnt_b;
  assign o_dir_seen = dir_seen;
  // Driver counts steps on both lines and latches direction at each step on line A
  always @(posedge i_clock) begin
    if (i_pulse_a === 1'b1) begin
      cnt_a <= cnt_a + 1;
      dir_seen <= i_dir;
    end
    if (i_pulse_b === 1'b1) cnt_b <= cnt_b + 1;
  end
endmodule : scc_motor_model
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scc_defs.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top;
  logic clk = 0, rst = 1, aw_v = 0, w_v = 0, ar_v = 0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h0, r_d;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, pa, pb, dir, hold, lcw, lccw;
  logic [1:0] b_rs, r_rs, last_rs;
  logic [3:0] w_s = 4'hF;
  logic b_rdy = 0, r_rdy = 0;
  logic cw_hit = 0, cw_nc = 0, cwc, ccwc, dseen;
  int cnt_a, cnt_b, bad_count = 0, cmp_count = 0;
  always #50 clk = ~clk;
  scc_channel #(.MS_CYCLES(10)) scc_channel_inst (
    .I_CLOCK(clk), .I_RESET(rst), .I_AWVALID(aw_v), .O_AWREADY(aw_rdy),
    .I_AWADDR(aw_a), .I_WVALID(w_v), .O_WREADY(w_rdy), .I_WDATA(w_d),
    .I_WSTRB(w_s), .O_BVALID(b_v), .I_BREADY(b_rdy), .O_BRESP(b_rs),
    .I_ARVALID(ar_v), .O_ARREADY(ar_rdy), .I_ARADDR(ar_a), .O_RVALID(r_v),
    .I_RREADY(r_rdy), .O_RDATA(r_d), .O_RRESP(r_rs), .I_LIMIT_CW(cwc),
    .I_LIMIT_CCW(ccwc), .O_PULSE_A(pa), .O_PULSE_B(pb), .O_DIR(dir),
    .O_HOLD_OFF(hold), .O_LIM_CW(lcw), .O_LIM_CCW(lccw));
  scc_motor_model scc_motor_model_inst (
    .i_clock(clk), .i_pulse_a(pa), .i_pulse_b(pb), .i_dir(dir),
    .i_cw_hit(cw_hit), .i_ccw_hit(1'b0), .i_cw_nc(cw_nc), .i_ccw_nc(1'b0),
    .o_cw_contact(cwc), .o_ccw_contact(ccwc), .o_cnt_a(cnt_a),
    .o_cnt_b(cnt_b), .o_dir_seen(dseen));
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task automatic tmo;
    bad_count++;
    $display("ERROR at %0t: wait limit used up", $time);
    finish_test();
  endtask : tmo
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'b1;
    aw_a <= a;
    w_d <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (aw_rdy === 1'b1) aw_v <= 1'b0;
      if (w_rdy === 1'b1) w_v <= 1'b0;
      if (b_v === 1'b1) break;
    end
    if (n == 50) tmo();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    ar_v <= 1'b1;
    ar_a <= a;
    r_rdy <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (ar_rdy === 1'b1) ar_v <= 1'b0;
      if (r_v === 1'b1) break;
    end
    d = r_d;
    last_rs = r_rs;
    if (n == 50) tmo();
  endtask : rd
  task automatic wait_state(input logic [4:0] s);
    logic [31:0] d;
    int n;
    for (n = 0; n < 400; n++) begin
      rd(`SCC_A_STAT, d);
      if (d[8:4] === s) break;
    end
    if (n == 400) tmo();
  endtask : wait_state
  task automatic t_reset;
    logic [7:0] a [10] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
      8'h1C, 8'h24, 8'h28, 8'h20};
    logic [31:0] e [10] = '{32'hE74, 32'h28A, 32'hA, 32'h1, 32'hD,
      32'h189, 32'h01F40050, 32'h47, 32'h0, 32'h18};
    logic [31:0] d;
    foreach (a[i]) begin
      rd(a[i], d);
      `CHK(d, e[i]);
    end
    rd(8'h2C, d);
    `CHK(last_rs, 2'h2);
    `CHK(d, 32'h0);
    wr(8'h2C, 32'h1);
    `CHK(b_rs, 2'h2);
  endtask : t_reset
  task automatic t_round;
    logic [7:0] a [10] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h0C, 8'h10,
      8'h10, 8'h14, 8'h1C, 8'h1C};
    logic [31:0] w [10] = '{32'h3, 32'h7, 32'h989676, 32'h98967F, 32'h0,
      32'h0, 32'h1869F, 32'h78, 32'h0BB80037, 32'h00140014};
    logic [31:0] e [10] = '{32'h5, 32'hA, 32'h989676, 32'h98967B, 32'h5,
      32'h1, 32'h1869F, 32'h73, 32'h0BB8003C, 32'h00320032};
    logic [31:0] d;
    foreach (a[i]) begin
      wr(a[i], w[i]);
      rd(a[i], d);
      `CHK(d, e[i]);
    end
    rd(`SCC_A_ACCT, d);
    `CHK(d, 32'h8);
    w_s <= 4'h1;
    wr(`SCC_A_JOG, 32'hFFFF0005);
    w_s <= 4'hF;
    rd(`SCC_A_JOG, d);
    `CHK(d, 32'h18605);
    wr(`SCC_A_LOW_SPEED_SETTING, 32'hF4240);
    wr(`SCC_A_HIGH_SPEED_SETTING, 32'hF4240);
    wr(`SCC_A_JOG, 32'h3);
  endtask : t_round
  task automatic t_page;
    logic [31:0] d;
    wr(`SCC_A_CMD, 32'h20);
    `CHK(b_rs, 2'h0);
    wr(`SCC_A_CMD, 32'h20);
    wr(`SCC_A_CMD, 32'h40);
    rd(`SCC_A_PAGE, d);
    `CHK(d, 32'h1);
    wr(`SCC_A_CMD, 32'h40);
    wr(`SCC_A_CMD, 32'h40);
    rd(`SCC_A_PAGE, d);
    `CHK(d, 32'hA);
  endtask : t_page
  task automatic t_fmt;
    int a0, b0;
    for (int f = 0; f < 3; f++) begin
      wr(`SCC_A_CFG, 32'h189 | (f << 1));
      a0 = cnt_a;
      b0 = cnt_b;
      wr(`SCC_A_CMD, 32'h1);
      wait_state(5'h01);
      if (f > 0) `CHK(dseen, f == 1);
      wr(`SCC_A_CMD, 32'h2);
      wait_state(5'h01);
      if (f > 0) `CHK(dseen, f == 2);
      `CHK(cnt_a - a0, f == 0 ? 3 : 6);
      `CHK(cnt_b - b0, f == 0 ? 3 : 0);
    end
  endtask : t_fmt
  task automatic t_hold;
    int n, a0;
    wr(`SCC_A_CFG, 32'h1A9);
    repeat (3) @(posedge clk);
    `CHK(hold, 1'b1);
    a0 = cnt_a;
    wr(`SCC_A_CMD, 32'h1);
    for (n = 0; n < 20 && hold === 1'b1; n++) @(posedge clk);
    for (n = 0; n < 2000 && cnt_a == a0; n++) @(posedge clk);
    `CHK(n >= 500 && n < 2000, 1'b1);
    for (n = 0; n < 200 && cnt_a != a0 + 3; n++) @(posedge clk);
    for (n = 0; n < 2000 && hold !== 1'b1; n++) @(posedge clk);
    `CHK(n >= 480 && n < 2000, 1'b1);
    wr(`SCC_A_CFG, 32'h1E9);
    repeat (3) @(posedge clk);
    `CHK(hold, 1'b0);
  endtask : t_hold
  task automatic run_check(input logic [31:0] cmd, input bit moves);
    int a0;
    a0 = cnt_a;
    wr(`SCC_A_CMD, cmd);
    repeat (100) @(posedge clk);
    `CHK(cnt_a != a0, moves);
  endtask : run_check
  task automatic stop_check;
    int a0;
    repeat (10) @(posedge clk);
    a0 = cnt_a;
    repeat (100) @(posedge clk);
    `CHK(cnt_a, a0);
  endtask : stop_check
  task automatic t_limit;
    wr(`SCC_A_CFG, 32'h989);
    cw_hit <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK({lcw, lccw}, 2'b10);
    run_check(32'h4, 0);
    cw_hit <= 1'b0;
    repeat (10) @(posedge clk);
    run_check(32'h4, 1);
    cw_hit <= 1'b1;
    stop_check();
    cw_hit <= 1'b0;
    wr(`SCC_A_CFG, 32'hB89);
    cw_nc <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(lcw, 1'b0);
    cw_hit <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(lcw, 1'b1);
    cw_nc <= 1'b0;
    wr(`SCC_A_CFG, 32'h1909);
    run_check(32'h4, 1);
    wr(`SCC_A_CMD, 32'h10);
    stop_check();
    cw_hit <= 1'b0;
    wr(`SCC_A_CFG, 32'h188);
    repeat (5) @(posedge clk);
    `CHK({lcw, lccw}, 2'b11);
    run_check(32'h1, 0);
  endtask : t_limit
  task automatic t_slow;
    logic [31:0] c [3] = '{32'h189, 32'h191, 32'h181};
    int a0;
    wr(`SCC_A_HIGH_SPEED_SETTING, 32'hF6950);
    foreach (c[k]) begin
      wr(`SCC_A_CFG, c[k]);
      wr(`SCC_A_CMD, 32'h4);
      repeat (500) @(posedge clk);
      if (k == 1) cw_hit <= 1'b1;
      else wr(`SCC_A_CMD, 32'h10);
      if (k < 2) begin
        wait_state(5'h08);
        a0 = cnt_a;
        wait_state(5'h01);
        `CHK(cnt_a != a0, 1'b1);
      end else begin
        stop_check();
      end
      cw_hit <= 1'b0;
    end
  endtask : t_slow
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_round();
    t_page();
    t_fmt();
    t_hold();
    wr(`SCC_A_CFG, 32'h189);
    t_limit();
    t_slow();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
